// File: design/acs_sequencer.sv
// Purpose: ADC conversion mode sequencer with APB registers
// Assumes: ADC core pulses conv_done with result after conv_start
// Notes:   Command register write stands for the serial command's end
//
// Contract
// - Start disabled: command write starts conversion
// - Start enabled: each start-pulse rising edge starts conversion
// - Start disabled: start-pulse pin ignored
// - Start enable is config bit 5
// - Single continuous repeats selected channel
// - Continuous: new trigger aborts and restarts
// - One-pass: enabled channels 0..15 ascending, idle
// - Looping: mask bits 15:8, channels 0..7, forever
// - Each conversion uses its channel slot
// - Multichannel retrigger restarts at lowest channel
// - Start pulse aborts, restarts last mode
// - Continuous modes stop only by abort or end command
// - Abort discards result, returns idle
// - End finishes conversion, stores, returns idle
// - Data-ready rises when result available
// - Filter reset: first period adds fixed delay
// - Filter reset off: later periods conversion only
// - Clock source bit selects external clock
// - Early revision: pulse only single modes
// - Single shot converts once, returns idle
`timescale 1ns/100ps
`include "acs_defs.svh"
`default_nettype none

module acs_sequencer
  import acs_pkg::*;
#(
  parameter int          NCH        = 16,
  parameter int          RW         = 24,
  parameter bit          EARLY_REV  = 1'b0
) (
  input  wire logic          sys_clk,        // System clock
  input  wire logic          reset,          // Async reset, high
  input  wire logic          psel,           // APB select
  input  wire logic          penable,        // APB enable
  input  wire logic          pwrite,         // APB direction
  input  wire logic [11:0]   paddr,          // APB byte address
  input  wire logic [31:0]   pwdata,         // APB write data
  output logic [31:0]        prdata,         // APB read data
  output logic               pready,         // APB ready
  output logic               pslverr,        // APB error
  input  wire logic          start_pulse,    // Start-pulse pin
  output logic               data_ready_output, // Result available
  output logic               clock_source_select, // 1: external clock
  output logic               conv_start,     // Start ADC conversion
  output logic               conv_abort,     // Abort ADC conversion
  output logic [3:0]         conv_channel,   // Slot for conversion
  input  wire logic          conv_done,      // ADC finished
  input  wire logic [RW-1:0] conv_data       // ADC result
);

  // Lowest enabled channel at or above from; bit 4 marks found
  function automatic logic [4:0] acs_next_chan(input logic [15:0] m,
                                               input logic [4:0]  from);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (m[i] && (5'(i) >= from)) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  logic [15:0]   sys_cfg;
  logic [15:0]   channel_enable_mask;
  logic [3:0]    chan_sel;
  logic [23:0]   prog_dly;
  logic [RW-1:0] channel_result_register [NCH];
  acs_state_e    state;
  acs_mode_e     mode;
  logic [23:0]   dly_cnt;
  logic          first_period;
  logic          end_pend;
  logic [2:0]    sync_ff;
  logic          sync_lvl;

  // APB decode
  wire       wr_en    = psel & penable & pwrite;
  wire       setup    = psel & ~penable;
  wire       hit_cfg  = (paddr == `ACS_OFF_SYSCFG);
  wire       hit_cmd  = (paddr == `ACS_OFF_CMD);
  wire       hit_mask = (paddr == `ACS_OFF_CHMASK);
  wire       hit_sel  = (paddr == `ACS_OFF_CHSEL);
  wire       hit_dly  = (paddr == `ACS_OFF_PROGDLY);
  wire       hit_stat = (paddr == `ACS_OFF_STATUS);
  wire       hit_res  = (paddr >= `ACS_OFF_RESULT) &&
                        (paddr <= `ACS_OFF_RESULT_END) &&
                        (paddr[1:0] == 2'b00);
  wire       mapped   = hit_cfg | hit_cmd | hit_mask | hit_sel |
                        hit_dly | hit_stat | hit_res;
  wire [3:0] res_idx  = paddr[5:2];
  wire [3:0] cmd_code = pwdata[3:0];
  wire       cmd_wr   = wr_en & hit_cmd;

  wire       ext_en   = sys_cfg[`ACS_SYSCFG_EXTSTRT];
  wire       filt_rst = sys_cfg[`ACS_SYSCFG_FILTRST];

  wire cmd_conv = cmd_wr & (cmd_code >= `ACS_CMD_SS) &
                  (cmd_code <= `ACS_MULTI_LOOPING_COMMAND);
  wire cmd_abt  = cmd_wr & (cmd_code == `ACS_CMD_ABT);
  wire cmd_end  = cmd_wr & (cmd_code == `ACS_CMD_END);
  wire busy     = (state != ACS_IDLE);

  // Mode a command selects; a start pulse reuses the last one
  wire acs_mode_e new_mode = cmd_conv ? acs_mode_e'(cmd_code[2:0]) : mode;

  // Start-pulse edge on the resynchronised level
  wire sync_stable = (sync_ff[1] == sync_ff[2]);
  wire sync_rise   = sync_stable & sync_ff[2] & ~sync_lvl;
  wire single_mode = (new_mode == ACS_M_SS) | (new_mode == ACS_M_SC);
  wire sync_ok     = ext_en & sync_rise &
                     (single_mode | ~EARLY_REV);

  // Trigger source follows the external start enable
  wire start_go = ext_en ? (sync_ok & (new_mode != ACS_M_NONE))
                         : cmd_conv;
  // Commands with start enabled only arm the mode

  wire multi_new  = (new_mode == ACS_M_MM) | (new_mode == ACS_M_MC);
  wire [15:0] mask_for_new = (new_mode == ACS_M_MC) ?
                             {8'h00, channel_enable_mask[15:8]}
                           : channel_enable_mask;
  wire [4:0] first_ch = acs_next_chan(mask_for_new, 5'h00);
  wire       start_ok = start_go & (~multi_new | first_ch[4]);
  wire [3:0] start_ch = multi_new ? first_ch[3:0] : chan_sel;

  // Following channel after a stored result
  wire [15:0] mask_cur = (mode == ACS_M_MC) ?
                         {8'h00, channel_enable_mask[15:8]}
                       : channel_enable_mask;
  wire [4:0] after_ch  = acs_next_chan(mask_cur,
                                       5'(conv_channel) + 5'h01);
  wire [4:0] wrap_ch   = acs_next_chan(mask_cur, 5'h00);

  // Result write: abort and retrigger take priority over completion
  wire res_we = (state == ACS_CONV) & conv_done & ~cmd_abt &
                ~start_go;

  // Delay before the next conversion of a pass
  wire [23:0] fix_cyc = 24'(`ACS_FIX_DLY_CYC);
  wire [23:0] dly_first = filt_rst ? (fix_cyc + prog_dly)
                                   : prog_dly;
  wire [23:0] dly_later = filt_rst ? prog_dly : 24'h000000;

  logic       cont;
  logic [3:0] cont_ch;
  always_comb begin
    cont    = 1'b0;
    cont_ch = conv_channel;
    case (mode)
      ACS_M_SC: begin
        cont = 1'b1;
      end
      ACS_M_MM: begin
        cont    = after_ch[4];
        cont_ch = after_ch[3:0];
      end
      ACS_M_MC: begin
        cont    = after_ch[4] | wrap_ch[4];
        cont_ch = after_ch[4] ? after_ch[3:0] : wrap_ch[3:0];
      end
      default: begin
        cont = 1'b0;
      end
    endcase
  end
  wire go_on = cont & ~end_pend;

  // Registers written by software
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sys_cfg             <= `ACS_SYSCFG_RST;
      channel_enable_mask <= 16'h0000;
      chan_sel            <= 4'h0;
      prog_dly            <= 24'h000000;
    end else if (wr_en) begin
      if (hit_cfg) begin
        sys_cfg <= pwdata[15:0];
      end
      if (hit_mask) begin
        channel_enable_mask <= pwdata[15:0];
      end
      if (hit_sel) begin
        chan_sel <= pwdata[3:0];
      end
      if (hit_dly) begin
        prog_dly <= pwdata[23:0];
      end
    end
  end

  assign clock_source_select = sys_cfg[`ACS_SYSCFG_CLKSRC];

  // Three-stage resync; level accepted when stages two and three agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_ff  <= 3'b000;
      sync_lvl <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[1:0], start_pulse};
      if (sync_stable) begin
        sync_lvl <= sync_ff[2];
      end
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state        <= ACS_IDLE;
      mode         <= ACS_M_NONE;
      dly_cnt      <= 24'h000000;
      first_period <= 1'b0;
      end_pend     <= 1'b0;
      conv_channel <= 4'h0;
      conv_start   <= 1'b0;
      conv_abort   <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      if (cmd_conv) begin
        mode <= new_mode;
      end
      if (cmd_abt) begin
        state    <= ACS_IDLE;
        end_pend <= 1'b0;
        if (busy) begin
          conv_abort <= 1'b1;
        end
      end else if (start_go) begin
        conv_abort <= busy;
        end_pend   <= 1'b0;
        if (start_ok) begin
          state        <= ACS_DELAY;
          dly_cnt      <= dly_first;
          first_period <= 1'b1;
          conv_channel <= start_ch;
        end else begin
          state <= ACS_IDLE;
        end
      end else begin
        if (cmd_end && busy) begin
          end_pend <= 1'b1;
        end
        case (state)
          ACS_DELAY: begin
            if (dly_cnt == 24'h000000) begin
              state      <= ACS_CONV;
              conv_start <= 1'b1;
            end else begin
              dly_cnt <= dly_cnt - 24'h000001;
            end
          end
          ACS_CONV: begin
            if (conv_done) begin
              first_period <= 1'b0;
              if (go_on) begin
                state        <= ACS_DELAY;
                dly_cnt      <= dly_later;
                conv_channel <= cont_ch;
              end else begin
                state    <= ACS_IDLE;
                end_pend <= 1'b0;
              end
            end
          end
          default: begin
            state <= ACS_IDLE;
          end
        endcase
      end
    end
  end

  // Results per slot and data-ready
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NCH; i++) begin
        channel_result_register[i] <= '0;
      end
      data_ready_output <= 1'b0;
    end else begin
      if (res_we) begin
        channel_result_register[conv_channel] <= conv_data;
        data_ready_output <= 1'b1;
      end else if (conv_start) begin
        data_ready_output <= 1'b0;
      end
    end
  end

  // APB read data captured in setup; zero wait state
  wire [31:0] stat_word = {16'h0000, end_pend, first_period, mode,
                           state, data_ready_output, ext_en, 3'b000,
                           conv_channel};
  wire [31:0] rd_mux =
      hit_cfg  ? {16'h0000, sys_cfg} :
      hit_mask ? {16'h0000, channel_enable_mask} :
      hit_sel  ? {28'h0000000, chan_sel} :
      hit_dly  ? {8'h00, prog_dly} :
      hit_stat ? stat_word :
      hit_res  ? 32'(channel_result_register[res_idx]) :
      32'h00000000;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= (pwrite ? 32'h00000000 : rd_mux);
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Checks
  a_sync_ignored: assert property (@(posedge sys_clk)
    disable iff (reset)
    (!ext_en && !cmd_wr && sync_rise && state == ACS_IDLE)
      |=> state == ACS_IDLE)
    else $error("start pulse acted while external start off");

  a_cmd_starts: assert property (@(posedge sys_clk)
    disable iff (reset)
    (!ext_en && cmd_wr && (cmd_code == `ACS_CMD_SS))
      |=> state == ACS_DELAY && conv_channel == $past(chan_sel))
    else $error("command did not start conversion");

  a_abort_clean: assert property (@(posedge sys_clk)
    disable iff (reset)
    (cmd_abt && busy) |-> !res_we ##1 (state == ACS_IDLE && conv_abort))
    else $error("abort did not discard and idle");

  a_end_finish: assert property (@(posedge sys_clk)
    disable iff (reset)
    (end_pend && res_we) |=> state == ACS_IDLE && data_ready_output)
    else $error("end command did not finish to idle");

  a_fix_delay: assert property (@(posedge sys_clk)
    disable iff (reset)
    (start_ok && !cmd_abt && filt_rst)
      |=> dly_cnt == fix_cyc + $past(prog_dly))
    else $error("first period lacks fixed delay");

  a_later_conv: assert property (@(posedge sys_clk)
    disable iff (reset)
    (res_we && go_on && !filt_rst) |=> ##1 conv_start)
    else $error("later period not conversion only");

  a_mm_ascend: assert property (@(posedge sys_clk)
    disable iff (reset)
    (res_we && mode == ACS_M_MM && go_on)
      |=> conv_channel > $past(conv_channel))
    else $error("one-pass order not ascending");

  a_loop_stays: assert property (@(posedge sys_clk)
    disable iff (reset)
    (res_we && mode == ACS_M_MC && !end_pend)
      |=> state == ACS_DELAY && conv_channel < 4'h8)
    else $error("looping pass left its channel range");

  a_ready_rise: assert property (@(posedge sys_clk)
    disable iff (reset)
    res_we |=> data_ready_output)
    else $error("data ready not raised on result");

endmodule

`default_nettype wire

// File: design/acs_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz sys_clk, APB byte addresses
// Notes:   Definitions only
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

`define ACS_OFF_SYSCFG     12'h000
`define ACS_OFF_CMD        12'h004
`define ACS_OFF_CHMASK     12'h008
`define ACS_OFF_CHSEL      12'h00c
`define ACS_OFF_PROGDLY    12'h010
`define ACS_OFF_STATUS     12'h014
`define ACS_OFF_RESULT     12'h040
`define ACS_OFF_RESULT_END 12'h07c

`define ACS_SYSCFG_FILTRST 0
`define ACS_SYSCFG_CLKSRC  1
`define ACS_SYSCFG_EXTSTRT 5
`define ACS_SYSCFG_RST     16'h0000

`define ACS_CMD_SS  4'h1
`define ACS_SINGLE_CONTINUOUS_COMMAND  4'h2
`define ACS_MULTI_ONE_PASS_COMMAND  4'h3
`define ACS_MULTI_LOOPING_COMMAND  4'h4
`define ACS_CMD_ABT 4'h5
`define ACS_CMD_END 4'h6

`define ACS_CLK_NS      10
`define ACS_FIX_DLY_NS  6076
`define ACS_FIX_DLY_CYC ((`ACS_FIX_DLY_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)

`endif

// File: design/acs_pkg.sv
// Purpose: Types shared by the conversion sequencer
// Assumes: Nothing
// Notes:   States are Gray coded along idle, delay, convert
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_DELAY = 2'b01,
    ACS_CONV  = 2'b11
  } acs_state_e;

  typedef enum logic [2:0] {
    ACS_M_NONE = 3'h0,
    ACS_M_SS   = 3'h1,
    ACS_M_SC   = 3'h2,
    ACS_M_MM   = 3'h3,
    ACS_M_MC   = 3'h4
  } acs_mode_e;
endpackage

// File: dv/acs_adc_model.sv
// Purpose: ADC core stand-in answering conversion starts
// Assumes: Result comes lat cycles after conv_start
// Notes:   Data line toggles while no result is offered
`timescale 1ns/100ps
`default_nettype none

module acs_adc_model (
  input  wire logic        sys_clk,      // System clock
  input  wire logic        reset,        // Async reset
  input  wire logic        conv_start,   // Start strobe
  input  wire logic        conv_abort,   // Kill strobe
  input  wire logic [3:0]  conv_channel, // Slot index
  input  wire logic [7:0]  salt,         // Marks the data
  input  wire logic [15:0] lat,          // Conversion cycles
  output logic             conv_done,    // Result strobe
  output logic [23:0]      conv_data     // Result
);
  logic [15:0] left;
  logic [19:0] tag;

  // Tag taken at start so a late salt change cannot leak in
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      left      <= '0;
      tag       <= '0;
      conv_done <= 1'b0;
      conv_data <= '0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_abort) begin
        left <= '0;
      end else if (conv_start) begin
        left <= lat;
        tag  <= {salt, 8'h0, conv_channel};
      end else if (left == 16'h1) begin
        left      <= '0;
        conv_done <= 1'b1;
        conv_data <= {4'h0, tag};
      end else if (left > 16'h1) begin
        left <= left - 16'h1;
      end
    end
  end
endmodule

`default_nettype wire

// File: dv/test_adc_conversion_mode_sequencer.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: ADC stand-in answers after lat cycles
// Notes:   Channel order and results come from the mask model
`timescale 1ns/100ps
`include "acs_defs.svh"
`default_nettype none

module test_adc_conversion_mode_sequencer;
  import acs_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        start_pulse = 1'b0;
  logic [7:0]  salt = '0;
  logic [15:0] lat = 16'h5;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, erv, data_ready_output;
  logic        clock_source_select, conv_start, conv_abort, conv_done;
  logic [3:0]  conv_channel;
  logic [23:0] conv_data;
  logic [3:0]  chq[$];
  int          miscompares = 0;
  int          total_checks = 0;
  int          aborts = 0;

  always #5 sys_clk = ~sys_clk;

  acs_sequencer dut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .start_pulse(start_pulse),
    .data_ready_output(data_ready_output),
    .clock_source_select(clock_source_select), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_data(conv_data)
  );

  acs_adc_model adc (
    .sys_clk(sys_clk), .reset(reset), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel), .salt(salt),
    .lat(lat), .conv_done(conv_done), .conv_data(conv_data)
  );

  always @(posedge sys_clk) begin
    if (conv_start === 1'b1) chq.push_back(conv_channel);
    if (conv_abort === 1'b1) aborts++;
  end

  function automatic logic [31:0] res(logic [7:0] s, logic [3:0] c);
    return {12'h0, s, 8'h0, c};
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tmo(input string m);
    miscompares++;
    $display("BAD %0t %s timed out", $time, m);
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo("pready");
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input logic [3:0] c);
    wr(`ACS_OFF_CMD, {28'h0, c});
  endtask

  // Held two clocks, the minimum the resync accepts as a level
  task automatic pulse;
    @(posedge sys_clk);
    start_pulse <= 1'b1;
    repeat (2) @(posedge sys_clk);
    start_pulse <= 1'b0;
  endtask

  task automatic wait_st(input int n);
    int k;
    k = 0;
    while (chq.size() < n && k < 5000) begin
      @(posedge sys_clk);
      k++;
    end
    if (chq.size() < n) tmo("start");
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(`ACS_OFF_STATUS);
      n++;
    end while (rdv[10:9] !== ACS_IDLE && n < 3000);
    if (n >= 3000) tmo("idle");
  endtask

  initial begin
    int n, m, a0;
    logic [15:0] mk;
    logic [7:0]  s1;
    logic [3:0]  eq[$];
    void'($urandom(18839));
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    rd(`ACS_OFF_SYSCFG);
    chk(rdv, 32'h0, "config reset");
    rd(12'h100);
    chk({erv, rdv[30:0]}, 32'h80000000, "unmapped");
    pulse();
    repeat (10) @(posedge sys_clk);
    chk(32'(chq.size()), 0, "pin ignored");
    salt <= 8'($urandom);
    wr(`ACS_OFF_CHSEL, 32'h5);
    cmd(`ACS_CMD_SS);
    wait_st(1);
    wait_idle();
    repeat (20) @(posedge sys_clk);
    chk(32'(chq.size()), 1, "single count");
    chk(32'(chq[0]), 5, "single chan");
    chk(32'(data_ready_output), 1, "ready");
    rd(`ACS_OFF_RESULT + 12'h14);
    chk(rdv, res(salt, 4'h5), "single data");
    $display("single shot done");
    for (int t = 0; t < 3; t++) begin
      mk = (t == 0) ? 16'($urandom) : (t == 1) ? 16'h0 : 16'h8001;
      chq.delete();
      wr(`ACS_OFF_CHMASK, {16'h0, mk});
      cmd(`ACS_MULTI_ONE_PASS_COMMAND);
      wait_idle();
      n = 0;
      for (int c = 0; c < 16; c++) if (mk[c]) n++;
      chk(32'(chq.size()), 32'(n), "pass length");
      n = 0;
      for (int c = 0; c < 16; c++) if (mk[c] && n < chq.size()) begin
        chk(32'(chq[n]), 32'(c), "pass order");
        rd(12'(`ACS_OFF_RESULT + 4 * c));
        chk(rdv, res(salt, 4'(c)), "pass data");
        n++;
      end
    end
    $display("one pass done");
    mk = {8'($urandom) | 8'h01, 8'h0};
    eq.delete();
    for (int i = 0; i < 8; i++) if (mk[8 + i]) eq.push_back(4'(i));
    m = eq.size();
    chq.delete();
    lat <= 16'd40;
    wr(`ACS_OFF_CHMASK, {16'h0, mk});
    cmd(`ACS_MULTI_LOOPING_COMMAND);
    wait_st(2 * m + 1);
    for (int k = 0; k < 2 * m; k++)
      chk(32'(chq[k]), 32'(eq[k % m]), "loop order");
    n = chq.size();
    a0 = aborts;
    cmd(`ACS_MULTI_LOOPING_COMMAND);
    wait_st(n + 1);
    chk(32'(chq[n]), 32'(eq[0]), "restart low");
    chk(32'(aborts > a0), 1, "retrigger kill");
    cmd(`ACS_CMD_ABT);
    wait_idle();
    n = chq.size();
    repeat (100) @(posedge sys_clk);
    chk(32'(chq.size()), 32'(n), "abort stops");
    $display("looping done");
    wr(`ACS_OFF_CHSEL, 32'h2);
    s1 = 8'($urandom);
    salt <= s1;
    lat <= 16'd5;
    chq.delete();
    cmd(`ACS_SINGLE_CONTINUOUS_COMMAND);
    wait_st(3);
    lat <= 16'd200;
    salt <= ~s1;
    wait_st(4);
    chk(32'(chq[3] == 2 && chq[1] == 2), 1, "repeat chan");
    cmd(`ACS_CMD_ABT);
    wait_idle();
    rd(`ACS_OFF_RESULT + 12'h8);
    chk(rdv, res(s1, 4'h2), "abort keeps");
    lat <= 16'd30;
    n = chq.size();
    cmd(`ACS_SINGLE_CONTINUOUS_COMMAND);
    wait_st(n + 1);
    cmd(`ACS_CMD_END);
    wait_idle();
    rd(`ACS_OFF_RESULT + 12'h8);
    chk(rdv, res(~s1, 4'h2), "end stores");
    $display("stop commands done");
    wr(`ACS_OFF_SYSCFG, 32'h20);
    rd(`ACS_OFF_SYSCFG);
    chk(rdv, 32'h20, "ext bit");
    chq.delete();
    wr(`ACS_OFF_CHSEL, 32'h6);
    cmd(`ACS_CMD_SS);
    repeat (20) @(posedge sys_clk);
    chk(32'(chq.size()), 0, "cmd no start");
    pulse();
    wait_st(1);
    chk(32'(chq[0]), 6, "pin start");
    wait_idle();
    lat <= 16'd100;
    cmd(`ACS_SINGLE_CONTINUOUS_COMMAND);
    pulse();
    wait_st(2);
    a0 = aborts;
    pulse();
    wait_st(3);
    chk(32'(aborts > a0), 1, "pin aborts");
    cmd(`ACS_CMD_ABT);
    wait_idle();
    $display("start pin done");
    lat <= 16'd5;
    wr(`ACS_OFF_PROGDLY, 32'h0);
    wr(`ACS_OFF_SYSCFG, 32'h3);
    // Config lands at the access edge; look one clock later
    @(posedge sys_clk);
    chk(32'(clock_source_select), 1, "clock source");
    chq.delete();
    cmd(`ACS_CMD_SS);
    n = 0;
    while (chq.size() == 0 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n >= 608 && n <= 615), 1, "first period");
    wait_idle();
    $display("timing done");
    give_verdict();
  end
endmodule

`default_nettype wire
